/* File: shared/fsp_pkg.sv */
// Purpose: Shared constants and carriers for the flash segment protection block
// Assumes: AXI4-Lite register bus, 32-bit data, one aligned word per register
// Notes: Configuration words are 24 bits wide and sit in the low bits of the bus word
package fsp_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned PAGE_W = 13;
  localparam int unsigned CFG_W = 24;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_SEC_CFG = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_LIM_CFG = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h008;

  // Field positions of segment_security_config
  localparam int unsigned POS_BOOT_LOCK = 0;
  localparam int unsigned POS_BOOT_LVL = 1;
  localparam int unsigned POS_BOOT_EN = 3;
  localparam int unsigned POS_GEN_LOCK = 5;
  localparam int unsigned POS_GEN_LVL = 6;
  localparam int unsigned POS_CFG_LOCK = 8;
  localparam int unsigned POS_CFG_LVL = 9;

  // Implemented program-once bits; all others read back as one
  localparam logic [CFG_W-1:0] SEC_IMPL_MASK = 24'h008fef;
  localparam logic [CFG_W-1:0] LIM_IMPL_MASK = 24'h001fff;
  localparam logic [CFG_W-1:0] CFG_ERASED = 24'hffffff;
  localparam logic [PAGE_W-1:0] LIM_ERASED = 13'h1fff;

  // First page of the configuration segment
  localparam logic [PAGE_W-1:0] CFG_PAGE_START = 13'h1fff;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FSP_LVL_NONE,
    FSP_LVL_STANDARD,
    FSP_LVL_ENHANCED,
    FSP_LVL_HIGH
  } fsp_level_t;

  typedef enum logic [1:0] {
    FSP_SEG_BOOT,
    FSP_SEG_GENERAL,
    FSP_SEG_CONFIG
  } fsp_seg_t;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } fsp_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fsp_axi_rsp_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [PAGE_W-1:0] page;
  } fsp_acc_req_t;

  typedef struct packed {
    logic done;
    logic allow;
    fsp_seg_t seg;
    fsp_level_t level;
  } fsp_acc_rsp_t;

endpackage : fsp_pkg

/* File: verilog/fsp_level_decode.sv */
// Purpose: Decodes one segment's protection level code and write lock bit
// Assumes: Two-bit level codes arrive widened as {b1, b1, b0}
// Notes: Purely combinational
`timescale 1ns/1ns
module fsp_level_decode (
  input wire logic [2:0] code_i,
  input wire logic lock_n_i,
  output fsp_pkg::fsp_level_t level_o,
  output logic writable_o
);

  always_comb begin
    if (code_i == 3'h7) begin
      level_o = fsp_pkg::FSP_LVL_NONE;
    end else if (code_i == 3'h6) begin
      level_o = fsp_pkg::FSP_LVL_STANDARD;
    end else if (code_i[2]) begin
      level_o = fsp_pkg::FSP_LVL_ENHANCED;
    end else begin
      level_o = fsp_pkg::FSP_LVL_HIGH;
    end
    // A cleared lock bit blocks program writes
    writable_o = lock_n_i;
  end

endmodule : fsp_level_decode

/* File: verilog/fsp_top.sv */
// Purpose: Program-once flash segment protection configuration and access check
// Assumes: reset_i marks power-on; AXI4-Lite slave on mclk_i
// Notes: Writes to the configuration words program zeros only; ones never return
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
module fsp_top (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire fsp_pkg::fsp_axi_req_t axi_req_i,
  output fsp_pkg::fsp_axi_rsp_t axi_rsp_o,
  input wire fsp_pkg::fsp_acc_req_t acc_req_i,
  output fsp_pkg::fsp_acc_rsp_t acc_rsp_o,
  output fsp_pkg::fsp_level_t boot_level_o,
  output fsp_pkg::fsp_level_t general_level_o,
  output fsp_pkg::fsp_level_t config_level_o
);

  typedef struct packed {
    logic [fsp_pkg::CFG_W-1:0] sec;
    logic [fsp_pkg::PAGE_W-1:0] lim;
    logic aw_have;
    logic [fsp_pkg::ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    fsp_pkg::fsp_axi_rsp_t axi;
    fsp_pkg::fsp_acc_rsp_t acc;
    fsp_pkg::fsp_level_t boot_lvl;
    fsp_pkg::fsp_level_t gen_lvl;
    fsp_pkg::fsp_level_t cfg_lvl;
  } fsp_state_t;

  fsp_state_t st_r;
  fsp_state_t st_nxt;

  logic [2:0] lvl_code [3];
  logic lock_n [3];
  fsp_pkg::fsp_level_t lvl [3];
  logic wr_ok [3];

  // Two-bit codes widen so 11 -> 111, 10 -> 110, 0x -> 00x
  assign lvl_code[0] = {st_r.sec[fsp_pkg::POS_BOOT_LVL+1], st_r.sec[fsp_pkg::POS_BOOT_LVL+1],
                        st_r.sec[fsp_pkg::POS_BOOT_LVL]};
  assign lvl_code[1] = {st_r.sec[fsp_pkg::POS_GEN_LVL+1], st_r.sec[fsp_pkg::POS_GEN_LVL+1],
                        st_r.sec[fsp_pkg::POS_GEN_LVL]};
  assign lvl_code[2] = st_r.sec[fsp_pkg::POS_CFG_LVL +: 3];
  assign lock_n[0] = st_r.sec[fsp_pkg::POS_BOOT_LOCK];
  assign lock_n[1] = st_r.sec[fsp_pkg::POS_GEN_LOCK];
  assign lock_n[2] = st_r.sec[fsp_pkg::POS_CFG_LOCK];

  for (genvar g = 0; g < 3; g++) begin : g_seg
    fsp_level_decode u_dec (
      .code_i(lvl_code[g]),
      .lock_n_i(lock_n[g]),
      .level_o(lvl[g]),
      .writable_o(wr_ok[g])
    );
  end

  // Boot segment covers pages below the inverted limit
  logic [fsp_pkg::PAGE_W-1:0] boot_end;
  logic boot_active;
  assign boot_end = ~st_r.lim;
  // Erased limit gives size zero; the enable bit is active when programmed low
  assign boot_active = (st_r.lim != fsp_pkg::LIM_ERASED) &&
                       !st_r.sec[fsp_pkg::POS_BOOT_EN];

  // Read views: unimplemented configuration bits return one; spare status bits return zero
  logic [fsp_pkg::CFG_W-1:0] sec_view;
  logic [fsp_pkg::CFG_W-1:0] lim_view;
  logic [31:0] status_view;
  assign sec_view = st_r.sec | ~fsp_pkg::SEC_IMPL_MASK;
  assign lim_view = {{(fsp_pkg::CFG_W-fsp_pkg::PAGE_W){1'b1}}, st_r.lim};
  assign status_view = {11'h000, boot_end, 1'b0, boot_active,
                        st_r.cfg_lvl, st_r.gen_lvl, st_r.boot_lvl};

  always_comb begin
    logic [31:0] bytemask;
    logic [31:0] keep;
    logic [fsp_pkg::ADDR_W-1:0] ra;
    fsp_pkg::fsp_seg_t seg;
    bytemask = '0;
    keep = '0;
    ra = '0;
    seg = fsp_pkg::FSP_SEG_GENERAL;
    st_nxt = st_r;

    // Write address and data may arrive in either order
    if (axi_req_i.awvalid && st_r.axi.awready) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.aw_addr = axi_req_i.awaddr;
    end
    if (axi_req_i.wvalid && st_r.axi.wready) begin
      st_nxt.w_have = 1'b1;
      st_nxt.w_data = axi_req_i.wdata;
      st_nxt.w_strb = axi_req_i.wstrb;
    end
    if (st_r.axi.bvalid && axi_req_i.bready) begin
      st_nxt.axi.bvalid = 1'b0;
    end
    if (st_r.aw_have && st_r.w_have && !st_r.axi.bvalid) begin
      for (int b = 0; b < 4; b++) begin
        bytemask[8*b +: 8] = {8{st_r.w_strb[b]}};
      end
      // Only zeros in enabled lanes program; a one never restores a bit
      keep = st_r.w_data | ~bytemask;
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have = 1'b0;
      st_nxt.axi.bvalid = 1'b1;
      st_nxt.axi.bresp = fsp_pkg::RESP_OKAY;
      unique case (st_r.aw_addr[fsp_pkg::ADDR_W-1:2])
        fsp_pkg::OFS_SEC_CFG[fsp_pkg::ADDR_W-1:2]: begin
          st_nxt.sec = st_r.sec & (keep[fsp_pkg::CFG_W-1:0] | ~fsp_pkg::SEC_IMPL_MASK);
        end
        fsp_pkg::OFS_LIM_CFG[fsp_pkg::ADDR_W-1:2]: begin
          st_nxt.lim = st_r.lim & keep[fsp_pkg::PAGE_W-1:0];
        end
        default: begin
          st_nxt.axi.bresp = fsp_pkg::RESP_SLVERR;
        end
      endcase
    end
    st_nxt.axi.awready = !st_nxt.aw_have && !st_nxt.axi.bvalid;
    st_nxt.axi.wready = !st_nxt.w_have && !st_nxt.axi.bvalid;

    // Read channel: one read outstanding
    if (st_r.axi.rvalid && axi_req_i.rready) begin
      st_nxt.axi.rvalid = 1'b0;
    end
    if (axi_req_i.arvalid && st_r.axi.arready) begin
      ra = axi_req_i.araddr;
      st_nxt.axi.rvalid = 1'b1;
      st_nxt.axi.rresp = fsp_pkg::RESP_OKAY;
      unique case (ra[fsp_pkg::ADDR_W-1:2])
        fsp_pkg::OFS_SEC_CFG[fsp_pkg::ADDR_W-1:2]: st_nxt.axi.rdata = {8'h00, sec_view};
        fsp_pkg::OFS_LIM_CFG[fsp_pkg::ADDR_W-1:2]: st_nxt.axi.rdata = {8'h00, lim_view};
        fsp_pkg::OFS_STATUS[fsp_pkg::ADDR_W-1:2]: st_nxt.axi.rdata = status_view;
        default: begin
          st_nxt.axi.rdata = 32'h0000_0000;
          st_nxt.axi.rresp = fsp_pkg::RESP_SLVERR;
        end
      endcase
    end
    st_nxt.axi.arready = !st_nxt.axi.rvalid;

    // Access check, answered one cycle after the request
    if (acc_req_i.page >= fsp_pkg::CFG_PAGE_START) begin
      seg = fsp_pkg::FSP_SEG_CONFIG;
    end else if (boot_active && (acc_req_i.page < boot_end)) begin
      seg = fsp_pkg::FSP_SEG_BOOT;
    end else begin
      seg = fsp_pkg::FSP_SEG_GENERAL;
    end
    st_nxt.acc.done = acc_req_i.valid;
    st_nxt.acc.seg = seg;
    unique case (seg)
      fsp_pkg::FSP_SEG_BOOT: begin
        st_nxt.acc.level = lvl[0];
        st_nxt.acc.allow = !acc_req_i.write || wr_ok[0];
      end
      fsp_pkg::FSP_SEG_GENERAL: begin
        st_nxt.acc.level = lvl[1];
        st_nxt.acc.allow = !acc_req_i.write || wr_ok[1];
      end
      default: begin
        st_nxt.acc.level = lvl[2];
        st_nxt.acc.allow = !acc_req_i.write || wr_ok[2];
      end
    endcase

    st_nxt.boot_lvl = lvl[0];
    st_nxt.gen_lvl = lvl[1];
    st_nxt.cfg_lvl = lvl[2];
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      // Power-on: every program-once bit reads as erased
      st_r.sec <= fsp_pkg::CFG_ERASED;
      st_r.lim <= fsp_pkg::LIM_ERASED;
      st_r.aw_have <= 1'b0;
      st_r.aw_addr <= '0;
      st_r.w_have <= 1'b0;
      st_r.w_data <= '0;
      st_r.w_strb <= '0;
      st_r.axi <= '0;
      st_r.acc <= '0;
      st_r.boot_lvl <= fsp_pkg::FSP_LVL_NONE;
      st_r.gen_lvl <= fsp_pkg::FSP_LVL_NONE;
      st_r.cfg_lvl <= fsp_pkg::FSP_LVL_NONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign axi_rsp_o = st_r.axi;
  assign acc_rsp_o = st_r.acc;
  assign boot_level_o = st_r.boot_lvl;
  assign general_level_o = st_r.gen_lvl;
  assign config_level_o = st_r.cfg_lvl;

endmodule : fsp_top

/* File: testbench/fsp_top_checker.sv */
// Purpose: Port assertions for fsp_top
// Assumes: Bound to every fsp_top instance
// Notes: Levels lag the words, so only their erased values are tied here
`timescale 1ns/1ns
module fsp_top_checker (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire fsp_pkg::fsp_axi_req_t axi_req_i,
  input wire fsp_pkg::fsp_axi_rsp_t axi_rsp_o,
  input wire fsp_pkg::fsp_acc_req_t acc_req_i,
  input wire fsp_pkg::fsp_acc_rsp_t acc_rsp_o,
  input wire fsp_pkg::fsp_level_t boot_level_o,
  input wire fsp_pkg::fsp_level_t general_level_o,
  input wire fsp_pkg::fsp_level_t config_level_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  a_done_follows: assert property (acc_req_i.valid |=> acc_rsp_o.done)
    else $error("done missing after request");
  a_done_pulse: assert property (!acc_req_i.valid |=> !acc_rsp_o.done)
    else $error("done without request");
  a_read_allowed: assert property (acc_req_i.valid && !acc_req_i.write |=> acc_rsp_o.allow)
    else $error("read refused");
  a_cfg_page_seg: assert property (acc_req_i.valid && acc_req_i.page == 13'h1fff
    |=> acc_rsp_o.seg == fsp_pkg::FSP_SEG_CONFIG) else $error("top page not config");
  a_erased_levels: assert property ($fell(reset_i) |-> boot_level_o == 2'h0
    && general_level_o == 2'h0 && config_level_o == 2'h0) else $error("level not erased");
  a_write_answer: assert property (axi_req_i.awvalid && axi_rsp_o.awready && axi_req_i.wvalid
    && axi_rsp_o.wready |-> ##[1:2] axi_rsp_o.bvalid) else $error("write not answered");
  a_bresp_holds: assert property (axi_rsp_o.bvalid && !axi_req_i.bready
    |=> axi_rsp_o.bvalid && $stable(axi_rsp_o.bresp)) else $error("write answer dropped");
  a_read_answer: assert property (axi_req_i.arvalid && axi_rsp_o.arready |=> axi_rsp_o.rvalid)
    else $error("read not answered");
  a_ar_refused: assert property (axi_rsp_o.rvalid |-> !axi_rsp_o.arready)
    else $error("address taken during answer");
  a_rdata_upper: assert property (axi_rsp_o.rvalid |-> axi_rsp_o.rdata[31:24] == 8'h00)
    else $error("upper read byte set");
endmodule : fsp_top_checker

bind fsp_top fsp_top_checker u_fsp_top_checker (.mclk_i(mclk_i), .reset_i(reset_i),
  .axi_req_i(axi_req_i), .axi_rsp_o(axi_rsp_o), .acc_req_i(acc_req_i), .acc_rsp_o(acc_rsp_o),
  .boot_level_o(boot_level_o), .general_level_o(general_level_o),
  .config_level_o(config_level_o));

/* File: testbench/fsp_acc_model.sv */
// Purpose: Flash access path issuing one checked request at a time
// Assumes: Called just after a rising edge
// Notes: Idle request lines show inverted values so stale data never looks valid
`timescale 1ns/1ns
module fsp_acc_model (
  input wire logic mclk_i,
  output fsp_pkg::fsp_acc_req_t acc_req_o,
  input wire fsp_pkg::fsp_acc_rsp_t acc_rsp_i
);
  initial acc_req_o = '0;
  task automatic access(input logic w, input logic [12:0] pg, output logic [5:0] r);
    acc_req_o <= '{valid: 1'b1, write: w, page: pg};
    @(posedge mclk_i);
    acc_req_o <= '{valid: 1'b0, write: ~w, page: ~pg};
    @(posedge mclk_i);
    r = {acc_rsp_i.done, acc_rsp_i.seg, acc_rsp_i.allow, acc_rsp_i.level};
  endtask : access
endmodule : fsp_acc_model

/* File: testbench/fsp_top_tb_top.sv */
// Purpose: Self-checking bench for fsp_top
// Assumes: One register transfer at a time
// Notes: Bits are only ever cleared, so scenario order matters
`timescale 1ns/1ns
module fsp_top_tb_top;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  fsp_pkg::fsp_axi_req_t req = '0;
  fsp_pkg::fsp_axi_rsp_t rsp;
  fsp_pkg::fsp_acc_req_t acc_req;
  fsp_pkg::fsp_acc_rsp_t acc_rsp;
  fsp_pkg::fsp_level_t lv_b, lv_g, lv_c;
  int fails = 0;
  int checks = 0;
  logic [23:0] sec = 24'hffffff;
  localparam fsp_pkg::fsp_level_t lvl_hi = fsp_pkg::FSP_LVL_HIGH;
  always #2 mclk_i = ~mclk_i;
  fsp_top u_fsp_top (.mclk_i(mclk_i), .reset_i(reset_i), .axi_req_i(req), .axi_rsp_o(rsp),
    .acc_req_i(acc_req), .acc_rsp_o(acc_rsp), .boot_level_o(lv_b), .general_level_o(lv_g),
    .config_level_o(lv_c));
  fsp_acc_model u_fsp_acc_model (.mclk_i(mclk_i), .acc_req_o(acc_req), .acc_rsp_i(acc_rsp));
  task automatic print_verdict();
    if (fails == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: 4'hf, bready: 1'b1,
      default: '0};
    do begin
      @(posedge mclk_i);
      n++;
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid && n < 40);
    req.bready <= 1'b0;
    chk({31'h0, rsp.bvalid}, 32'h1);
    if (!rsp.bvalid) print_verdict();
    chk({30'h0, rsp.bresp}, {30'h0, er});
    // Let an edge pass so the next request never reassigns the bus in this step
    @(posedge mclk_i);
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n = 0;
    req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
    do begin
      @(posedge mclk_i);
      n++;
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid && n < 40);
    req.rready <= 1'b0;
    chk({31'h0, rsp.rvalid}, 32'h1);
    if (!rsp.rvalid) print_verdict();
    chk(rsp.rdata, ed);
    chk({30'h0, rsp.rresp}, {30'h0, er});
    @(posedge mclk_i);
  endtask : axi_rd
  task automatic prog(input int p);
    axi_wr(fsp_pkg::OFS_SEC_CFG, ~(32'h1 << p), fsp_pkg::RESP_OKAY);
    sec[p] = 1'b0;
  endtask : prog
  task automatic acc(input logic w, input logic [12:0] pg, input fsp_pkg::fsp_seg_t s,
    input logic ok, input fsp_pkg::fsp_level_t lv);
    logic [5:0] r;
    u_fsp_acc_model.access(w, pg, r);
    chk({26'h0, r}, {26'h0, 1'b1, s, ok, lv});
  endtask : acc
  task automatic t_erased();
    axi_rd(fsp_pkg::OFS_SEC_CFG, 32'h00ffffff, fsp_pkg::RESP_OKAY);
    axi_rd(fsp_pkg::OFS_LIM_CFG, 32'h00ffffff, fsp_pkg::RESP_OKAY);
    axi_rd(fsp_pkg::OFS_STATUS, 32'h0, fsp_pkg::RESP_OKAY);
    axi_rd(12'h00c, 32'h0, fsp_pkg::RESP_SLVERR);
    axi_wr(fsp_pkg::OFS_STATUS, 32'h0, fsp_pkg::RESP_SLVERR);
  endtask : t_erased
  task automatic t_levels();
    int pos [8] = '{3, 9, 10, 11, 1, 7, 6, 2};
    logic [5:0] lv [8] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h13, 6'h1f, 6'h1f, 6'h3f};
    for (int i = 0; i < 8; i++) begin
      prog(pos[i]);
      repeat (2) @(posedge mclk_i);
      chk({26'h0, lv_b, lv_g, lv_c}, {26'h0, lv[i]});
      // All three levels differ only here, so the access level select is visible
      if (i == 4) begin
        acc(1'b0, 13'h0000, fsp_pkg::FSP_SEG_GENERAL, 1'b1, fsp_pkg::FSP_LVL_NONE);
        acc(1'b1, 13'h1fff, fsp_pkg::FSP_SEG_CONFIG, 1'b1, lvl_hi);
      end
    end
    axi_wr(fsp_pkg::OFS_SEC_CFG, 32'hffffffff, fsp_pkg::RESP_OKAY);
    axi_rd(fsp_pkg::OFS_SEC_CFG, {8'h00, sec}, fsp_pkg::RESP_OKAY);
  endtask : t_levels
  task automatic t_limit();
    acc(1'b1, 13'h0000, fsp_pkg::FSP_SEG_GENERAL, 1'b1, lvl_hi);
    axi_wr(fsp_pkg::OFS_LIM_CFG, 32'h00001fef, fsp_pkg::RESP_OKAY);
    acc(1'b1, 13'h000f, fsp_pkg::FSP_SEG_BOOT, 1'b1, lvl_hi);
    acc(1'b1, 13'h0010, fsp_pkg::FSP_SEG_GENERAL, 1'b1, lvl_hi);
    axi_wr(fsp_pkg::OFS_LIM_CFG, 32'h00001fe0, fsp_pkg::RESP_OKAY);
    acc(1'b1, 13'h0010, fsp_pkg::FSP_SEG_BOOT, 1'b1, lvl_hi);
    acc(1'b1, 13'h001f, fsp_pkg::FSP_SEG_GENERAL, 1'b1, lvl_hi);
    axi_rd(fsp_pkg::OFS_LIM_CFG, 32'h00ffffe0, fsp_pkg::RESP_OKAY);
    axi_rd(fsp_pkg::OFS_STATUS, 32'h00001f7f, fsp_pkg::RESP_OKAY);
  endtask : t_limit
  task automatic t_locks();
    acc(1'b1, 13'h1fff, fsp_pkg::FSP_SEG_CONFIG, 1'b1, lvl_hi);
    prog(0);
    acc(1'b1, 13'h0000, fsp_pkg::FSP_SEG_BOOT, 1'b0, lvl_hi);
    acc(1'b0, 13'h0000, fsp_pkg::FSP_SEG_BOOT, 1'b1, lvl_hi);
    prog(5);
    acc(1'b1, 13'h0020, fsp_pkg::FSP_SEG_GENERAL, 1'b0, lvl_hi);
    prog(8);
    acc(1'b1, 13'h1fff, fsp_pkg::FSP_SEG_CONFIG, 1'b0, lvl_hi);
  endtask : t_locks
  initial begin
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    t_erased();
    t_levels();
    t_limit();
    t_locks();
    print_verdict();
  end
endmodule : fsp_top_tb_top
